// ---- rtl/ppds_map.svh ----
`ifndef PPDS_MAP_SVH
`define PPDS_MAP_SVH

// Register byte offsets.
`define PPDS_OFF_CTRL 8'h00
`define PPDS_OFF_PICKUP 8'h04
`define PPDS_OFF_FIXDLY 8'h08
`define PPDS_OFF_KMUL 8'h0C
`define PPDS_OFF_CONST_A 8'h10
`define PPDS_OFF_CONST_B 8'h14
`define PPDS_OFF_STATUS 8'h18
`define PPDS_OFF_IRQ_STAT 8'h1C
`define PPDS_OFF_IRQ_MASK 8'h20
`define PPDS_OFF_EVT_TIME 8'h24
`define PPDS_OFF_EVT_DATA 8'h28
`define PPDS_OFF_DEN_BASE 8'h40
`define PPDS_OFF_DEN_LAST 8'h7C

// Control fields.
`define PPDS_CTRL_INV_BIT 0
`define PPDS_CTRL_IEEE_BIT 1
`define PPDS_CTRL_UNDER_BIT 2

// Interrupt status fields.
`define PPDS_IRQ_START_BIT 0
`define PPDS_IRQ_TRIP_BIT 1
`define PPDS_IRQ_BLOCK_BIT 2

// Reset values.
`define PPDS_RST_CTRL 3'h0
`define PPDS_RST_PICKUP 16'h03E8
`define PPDS_RST_FIXDLY 16'h0008
`define PPDS_RST_KMUL 12'h005
`define PPDS_RST_CONST_A 16'h0360
`define PPDS_RST_CONST_B 16'h073A
`define PPDS_RST_DEN 16'h03E8
`define PPDS_RST_MASK 3'h0

// Hysteresis in percent of the pick-up setting.
`define PPDS_RESET_PCT 7'd97
`define PPDS_FULL_PCT 7'd100

// Timing.
`define PPDS_CLK_NS 10
`define PPDS_CYCLE_MS 1
`define PPDS_FIX_STEP_MS 5
`define PPDS_FIX_STEP_CYC (`PPDS_FIX_STEP_MS / `PPDS_CYCLE_MS)
`define PPDS_CYCLE_CLKS (`PPDS_CYCLE_MS * 1000000 / `PPDS_CLK_NS)
// Accumulator step during the constant tail of the IEEE curve.
`define PPDS_TAIL_STEP 32'h0000_03E8

`endif

// ---- rtl/ppds_pkg.sv ----
`default_nettype none
package ppds_pkg;

  typedef enum logic [1:0] {
    PPDS_IDLE = 2'b00,
    PPDS_START = 2'b01,
    PPDS_BLOCKED = 2'b10
  } ppds_state_t;

  typedef enum logic {
    PPDS_INTEG = 1'b0,
    PPDS_TAIL = 1'b1
  } ppds_phase_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0] fault;
    logic [15:0] mag;
  } ppds_evt_t;

  typedef struct packed {
    logic picked;
    logic start;
    logic blocked;
    logic trip;
  } ppds_out_t;

endpackage
`default_nettype wire

// ---- rtl/ppds_stage.sv ----
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ppds_map.svh"

// Contract
// - Compare measured magnitude with pick-up setting as over or under limit, every cycle.
// - Release only when magnitude crosses back past 97 % of the setting; under mode releases only above 100/97 of the setting.
// - Sample the blocking input at the start of each processing cycle.
// - Pick-up without blocking asserts start and starts the operating timer.
// - Pick-up with blocking asserts blocked, no start, timer held.
// - Blocking clears active start, then release timing as for a pick-up reset.
// - Each blocking occurrence emits a time-stamped record with magnitude and fault type.
// - Instant operation trips in the same cycle as start.
// - Fixed mode trips after the set delay of continuous pick-up.
// - Inverse mode trips after a delay set by the magnitude to setting ratio.
// - In inverse mode the fixed delay is a floor; zero disables it.
// - Delay type selects fixed or inverse mode; default fixed.
// - Fixed delay is the operating time, 5 ms steps, default 40 ms.
// - Fixed delay zero gives instant operation, nonzero gives delayed operation.
// - Curve series picks IEC or IEEE, default IEC, only in inverse mode.
// - IEC time k*A/(r^B-1); IEEE time k*(A/(r^C-1)+B).
// - Multiplier k in 10 ms steps, default 50 ms, inverse mode only.
module ppds_stage #(
  parameter int unsigned CYCLE_CLKS = `PPDS_CYCLE_CLKS,
  parameter int unsigned TW = 20
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement and blocking matrix.
  input wire logic [15:0] mag,
  input wire logic block_in,
  // Stage outputs.
  output ppds_pkg::ppds_out_t stage_out,
  output logic evt_valid,
  output ppds_pkg::ppds_evt_t evt,
  output logic irq
);
  import ppds_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [4:0] count_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // Settings.
  logic [2:0] ctrl;
  logic [15:0] pickup;
  logic [15:0] fixdly;
  logic [11:0] kmul;
  logic [15:0] const_a;
  logic [15:0] const_b;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [15:0] den [16];
  ppds_evt_t evt_rec;

  // Stage state.
  ppds_state_t state;
  ppds_phase_t phase;
  logic picked;
  logic trip;
  logic curve_done;
  logic [TW-1:0] timer;
  logic [31:0] acc;
  logic [31:0] stamp;
  logic [31:0] divcnt;

  // APB decode.
  wire wr_en = psel && penable && pwrite;
  wire [7:0] addr = {paddr[7:2], 2'b00};
  wire den_hit = (addr >= `PPDS_OFF_DEN_BASE) && (addr <= `PPDS_OFF_DEN_LAST);
  wire [3:0] den_idx = addr[5:2];
  wire reg_hit = den_hit || (addr == `PPDS_OFF_CTRL) || (addr == `PPDS_OFF_PICKUP)
      || (addr == `PPDS_OFF_FIXDLY) || (addr == `PPDS_OFF_KMUL)
      || (addr == `PPDS_OFF_CONST_A) || (addr == `PPDS_OFF_CONST_B)
      || (addr == `PPDS_OFF_STATUS) || (addr == `PPDS_OFF_IRQ_STAT)
      || (addr == `PPDS_OFF_IRQ_MASK) || (addr == `PPDS_OFF_EVT_TIME)
      || (addr == `PPDS_OFF_EVT_DATA);
  wire do_wr = wr_en && reg_hit;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit;

  always_comb begin
    prdata = 32'h0000_0000;
    if (den_hit) begin
      prdata = {16'h0000, den[den_idx]};
    end else begin
      unique case (addr)
        `PPDS_OFF_CTRL: prdata = {29'h0, ctrl};
        `PPDS_OFF_PICKUP: prdata = {16'h0, pickup};
        `PPDS_OFF_FIXDLY: prdata = {16'h0, fixdly};
        `PPDS_OFF_KMUL: prdata = {20'h0, kmul};
        `PPDS_OFF_CONST_A: prdata = {16'h0, const_a};
        `PPDS_OFF_CONST_B: prdata = {16'h0, const_b};
        `PPDS_OFF_STATUS: prdata = {28'h0, picked, trip, state == PPDS_BLOCKED,
                                    state == PPDS_START};
        `PPDS_OFF_IRQ_STAT: prdata = {29'h0, irq_stat};
        `PPDS_OFF_IRQ_MASK: prdata = {29'h0, irq_mask};
        `PPDS_OFF_EVT_TIME: prdata = evt_rec.stamp;
        `PPDS_OFF_EVT_DATA: prdata = {14'h0, evt_rec.fault, evt_rec.mag};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Processing-cycle strobe and time base for event stamps.
  wire tick = (divcnt == CYCLE_CLKS - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divcnt <= 32'h0000_0000;
      stamp <= 32'h0000_0000;
    end else begin
      divcnt <= tick ? 32'h0000_0000 : divcnt + 32'h0000_0001;
      stamp <= tick ? stamp + 32'h0000_0001 : stamp;
    end
  end

  // Mode selection.
  wire inv_mode = ctrl[`PPDS_CTRL_INV_BIT];
  wire ieee = inv_mode && ctrl[`PPDS_CTRL_IEEE_BIT];
  wire under = ctrl[`PPDS_CTRL_UNDER_BIT];

  // Pick-up comparison with reset hysteresis relative to the setting.
  wire [22:0] mag_pct = mag * `PPDS_FULL_PCT;
  wire [22:0] set_pct = pickup * `PPDS_FULL_PCT;
  wire [22:0] mag_rst = mag * `PPDS_RESET_PCT;
  wire [22:0] set_rst = pickup * `PPDS_RESET_PCT;
  wire operate = under ? (mag < pickup) : (mag > pickup);
  wire release_lvl = under ? (mag_rst > set_pct) : (mag_pct < set_rst);
  wire next_picked = picked ? !release_lvl : operate;

  // Ratio bucket: hit[i] when magnitude is at least (5+i)/4 of the setting.
  logic [15:0] ratio_hit;
  wire [17:0] mag_x4 = {mag, 2'b00};
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_ratio
      wire [20:0] thr = pickup * 5'(5 + gi);
      assign ratio_hit[gi] = {3'b000, mag_x4} >= thr;
    end
  endgenerate
  wire [4:0] bucket_raw = count_ones(ratio_hit);
  wire [3:0] bucket = bucket_raw[4] ? 4'hF : bucket_raw[3:0];

  // Curve integration: table holds (r^exponent - 1) scaled so that the sum reaches k*A.
  wire [27:0] ka = kmul * const_a;
  wire [27:0] kb = kmul * const_b;
  wire [31:0] step = (phase == PPDS_TAIL) ? `PPDS_TAIL_STEP : {16'h0000, den[bucket]};
  wire [31:0] acc_sum = acc + step;
  wire [27:0] goal = (phase == PPDS_TAIL) ? kb : ka;
  wire seg_hit = acc_sum >= {4'h0, goal};
  wire next_curve_done = curve_done || (seg_hit && (ieee ? phase == PPDS_TAIL : 1'b1));

  // Operating timer in processing cycles.
  wire [18:0] fix_cyc = fixdly * 3'(`PPDS_FIX_STEP_CYC);
  wire [TW-1:0] timer_inc = timer + TW'(1);
  wire fix_done = {{(TW > 19 ? TW - 19 : 0){1'b0}}, fix_cyc} <= timer_inc;
  wire floor_ok = (fix_cyc == 19'h0) || fix_done;
  wire next_trip = inv_mode ? (next_curve_done && floor_ok) : fix_done;

  // Stage evaluation, once per processing cycle; pick-up is decided first, then blocking.
  ppds_state_t next_state;
  always_comb begin
    if (!next_picked) begin
      next_state = PPDS_IDLE;
    end else if (block_in) begin
      next_state = PPDS_BLOCKED;
    end else begin
      next_state = PPDS_START;
    end
  end

  wire blk_event = tick && (next_state == PPDS_BLOCKED) && (state != PPDS_BLOCKED);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PPDS_IDLE;
      picked <= 1'b0;
      trip <= 1'b0;
      timer <= '0;
      acc <= 32'h0000_0000;
      phase <= PPDS_INTEG;
      curve_done <= 1'b0;
    end else if (tick) begin
      picked <= next_picked;
      state <= next_state;
      if (next_state == PPDS_START) begin
        timer <= timer_inc;
        trip <= next_trip;
        curve_done <= next_curve_done;
        acc <= (seg_hit && phase == PPDS_INTEG) ? 32'h0000_0000 : acc_sum;
        phase <= (seg_hit && ieee) ? PPDS_TAIL : phase;
      end else begin
        timer <= '0;
        trip <= 1'b0;
        curve_done <= 1'b0;
        acc <= 32'h0000_0000;
        phase <= PPDS_INTEG;
      end
    end
  end

  // Event record of each blocking occurrence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_rec <= '0;
      evt_valid <= 1'b0;
    end else begin
      evt_valid <= blk_event;
      if (blk_event) begin
        evt_rec <= '{stamp: stamp, fault: {state == PPDS_START, under}, mag: mag};
      end
    end
  end
  assign evt = evt_rec;

  // Registers; a hardware event wins over a clearing write in the same cycle.
  wire start_rise = tick && next_state == PPDS_START && state != PPDS_START;
  wire trip_rise = tick && next_state == PPDS_START && next_trip && !trip;
  wire [2:0] irq_set = {blk_event, trip_rise, start_rise};
  wire [31:0] wd_stat = merge(32'h0, pwdata, pstrb);
  wire [2:0] irq_clr = (do_wr && addr == `PPDS_OFF_IRQ_STAT) ? wd_stat[2:0] : 3'h0;
  // Byte-lane merges of each writable register with its current value.
  wire [31:0] m_ctrl = merge({29'h0, ctrl}, pwdata, pstrb);
  wire [31:0] m_pickup = merge({16'h0, pickup}, pwdata, pstrb);
  wire [31:0] m_fixdly = merge({16'h0, fixdly}, pwdata, pstrb);
  wire [31:0] m_kmul = merge({20'h0, kmul}, pwdata, pstrb);
  wire [31:0] m_const_a = merge({16'h0, const_a}, pwdata, pstrb);
  wire [31:0] m_const_b = merge({16'h0, const_b}, pwdata, pstrb);
  wire [31:0] m_mask = merge({29'h0, irq_mask}, pwdata, pstrb);
  wire [31:0] m_den = merge({16'h0, den[den_idx]}, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PPDS_RST_CTRL;
      pickup <= `PPDS_RST_PICKUP;
      fixdly <= `PPDS_RST_FIXDLY;
      kmul <= `PPDS_RST_KMUL;
      const_a <= `PPDS_RST_CONST_A;
      const_b <= `PPDS_RST_CONST_B;
      irq_mask <= `PPDS_RST_MASK;
      irq_stat <= 3'h0;
      for (int i = 0; i < 16; i++) begin
        den[i] <= `PPDS_RST_DEN;
      end
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (do_wr) begin
        if (den_hit) begin
          den[den_idx] <= m_den[15:0];
        end
        unique case (addr)
          `PPDS_OFF_CTRL: ctrl <= m_ctrl[2:0];
          `PPDS_OFF_PICKUP: pickup <= m_pickup[15:0];
          `PPDS_OFF_FIXDLY: fixdly <= m_fixdly[15:0];
          `PPDS_OFF_KMUL: kmul <= m_kmul[11:0];
          `PPDS_OFF_CONST_A: const_a <= m_const_a[15:0];
          `PPDS_OFF_CONST_B: const_b <= m_const_b[15:0];
          `PPDS_OFF_IRQ_MASK: irq_mask <= m_mask[2:0];
          default: ;
        endcase
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);
  assign stage_out = '{picked: picked, start: state == PPDS_START,
                       blocked: state == PPDS_BLOCKED, trip: trip};

  // Checks.
  sequence s_block_on_start;
    tick && block_in && next_picked && state == PPDS_START;
  endsequence

  sequence s_under_release;
    tick && picked && under && mag_rst > set_pct;
  endsequence

  sequence s_fresh_pickup;
    tick && !picked && !under && mag > pickup && !block_in;
  endsequence

  a_pickup_starts: assert property (s_fresh_pickup |=> stage_out.start && picked)
    else $error("Pick-up without blocking did not raise start.");

  a_release_drops: assert property (
    tick && picked && !under && mag_pct < set_rst |=> !picked && !stage_out.start && !trip)
    else $error("Release below reset level did not drop the stage.");

  a_block_kills_start: assert property (
    s_block_on_start |=> !stage_out.start && stage_out.blocked && timer == '0 && !trip)
    else $error("Blocking did not clear start.");

  a_blocked_quiet: assert property (
    stage_out.blocked |-> !stage_out.start && !trip && timer == '0)
    else $error("Blocked stage shows start or a running timer.");

  a_block_event: assert property (
    $rose(stage_out.blocked) |-> evt_valid && evt.stamp == $past(stamp))
    else $error("Blocking occurred without an event record.");

  a_instant_trip: assert property (
    $rose(stage_out.start) && !inv_mode && fixdly == 16'h0 |-> trip)
    else $error("Instant operation did not trip with start.");

  a_fixed_timing: assert property (
    stage_out.start && !inv_mode |-> trip == ({{(TW > 19 ? TW - 19 : 0){1'b0}}, fix_cyc} <= timer))
    else $error("Fixed delay trip does not match the timer.");

  a_inverse_floor: assert property (
    trip && inv_mode && fixdly != 16'h0 |-> {{(TW > 19 ? TW - 19 : 0){1'b0}}, fix_cyc} <= timer)
    else $error("Inverse trip came before the minimum delay.");

  a_trip_needs_start: assert property (
    trip |-> stage_out.start && timer != '0)
    else $error("Trip stands without start.");

  a_timer_steps: assert property (
    tick && state == PPDS_START && next_state == PPDS_START |=> timer == $past(timer_inc))
    else $error("Operating timer did not advance one step per processing cycle.");

  a_under_release: assert property (
    s_under_release |=> !picked && !stage_out.start && !trip)
    else $error("Under-limit release did not drop the stage.");

  a_timer_clear: assert property (
    tick && next_state != PPDS_START |=> timer == '0 && !trip)
    else $error("Timer or trip survived the end of start.");

  a_trip_on_tick: assert property (
    $rose(trip) |-> $past(tick))
    else $error("Trip rose outside a processing cycle.");

  a_start_flag: assert property (
    $rose(stage_out.start) |-> irq_stat[`PPDS_IRQ_START_BIT])
    else $error("Start rose without its status flag.");

  a_event_data: assert property (
    evt_valid |-> evt.mag == $past(mag) && irq_stat[`PPDS_IRQ_BLOCK_BIT])
    else $error("Blocking record lacks magnitude or status flag.");

endmodule
`default_nettype wire

// ---- bench/ppds_meas_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppds_meas_src (
  // Clock.
  input wire logic pclk,
  // Measurement and blocking towards the stage.
  output logic [15:0] mag,
  output logic block_in
);
  initial begin
    mag = 16'h0000;
    block_in = 1'b0;
  end
  // Values change only just after an edge; t_block raises blocking well
  // ahead of the end of the operating delay, t_under only after the trip.
  task automatic drive(input logic [15:0] m, input logic b);
    @(posedge pclk);
    mag <= m;
    block_in <= b;
  endtask
endmodule
`default_nettype wire

// ---- bench/protection_pickup_delay_stage_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ppds_map.svh"
module protection_pickup_delay_stage_test;
  import ppds_pkg::*;
  localparam int unsigned CYC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] mag;
  logic block_in;
  ppds_out_t stage_out;
  logic evt_valid;
  ppds_evt_t evt;
  logic irq;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic er;
  int t0, t1, t2;

  always #5 pclk = ~pclk;

  ppds_stage #(.CYCLE_CLKS(CYC)) i_ppds_stage (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mag(mag), .block_in(block_in),
    .stage_out(stage_out), .evt_valid(evt_valid), .evt(evt), .irq(irq));
  ppds_meas_src i_ppds_meas_src (.pclk(pclk), .mag(mag), .block_in(block_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Answer signals are read in the low half of the access cycle, where they
  // stand unchanged up to the rising edge that completes the transfer.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Counts clocks until one stage output bit reaches the given level.
  task automatic wait_bit(input int b, input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (stage_out[b] !== v && n < 3000);
    if (n >= 3000) check("wait", 0, 1);
  endtask

  task automatic meas(input logic [15:0] m, output int n);
    i_ppds_meas_src.drive(m, 1'b0);
    wait_bit(2, 1'b1, t2);
    wait_bit(0, 1'b1, n);
    i_ppds_meas_src.drive(16'h0000, 1'b0);
    wait_bit(3, 1'b0, t2);
  endtask

  task automatic t_reset();
    check("outs", stage_out, 4'h0);
    apb(1'b0, `PPDS_OFF_CTRL, 0);
    check("ctrl", rd, 0);
    apb(1'b0, `PPDS_OFF_PICKUP, 0);
    check("pickup", rd, 32'h0000_03E8);
    apb(1'b0, `PPDS_OFF_FIXDLY, 0);
    check("fixdly", rd, 32'h0000_0008);
    apb(1'b0, `PPDS_OFF_KMUL, 0);
    check("kmul", rd, 32'h0000_0005);
    apb(1'b0, 8'h30, 0);
    check("unmapped", er, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
    $display("t_reset done");
  endtask

  task automatic t_fixed();
    apb(1'b1, `PPDS_OFF_FIXDLY, 32'h0000_0001);
    i_ppds_meas_src.drive(16'h04B0, 1'b0);
    wait_bit(2, 1'b1, t0);
    check("picked", stage_out.picked, 1'b1);
    check("early trip", stage_out.trip, 1'b0);
    wait_bit(0, 1'b1, t1);
    check("fixed time", t1, 4 * CYC);
    i_ppds_meas_src.drive(16'h03D4, 1'b0);
    repeat (3 * CYC) @(posedge pclk);
    #1;
    check("hold at 98", stage_out.picked, 1'b1);
    i_ppds_meas_src.drive(16'h03C0, 1'b0);
    wait_bit(3, 1'b0, t1);
    check("release time", t1 <= CYC, 1'b1);
    check("trip cleared", stage_out.trip, 1'b0);
    apb(1'b1, `PPDS_OFF_FIXDLY, 0);
    meas(16'h04B0, t1);
    check("instant", t1, 1);
    $display("t_fixed done");
  endtask

  task automatic t_block();
    apb(1'b1, `PPDS_OFF_FIXDLY, 32'h0000_0008);
    i_ppds_meas_src.drive(16'h044C, 1'b1);
    wait_bit(1, 1'b1, t0);
    check("no start", stage_out.start, 1'b0);
    check("evt pulse", evt_valid, 1'b1);
    check("evt mag", evt.mag, 16'h044C);
    check("evt fault", evt.fault, 2'h0);
    check("irq masked", irq, 1'b0);
    apb(1'b1, `PPDS_OFF_IRQ_MASK, 32'h0000_0004);
    check("irq on", irq, 1'b1);
    apb(1'b0, `PPDS_OFF_STATUS, 0);
    check("status", rd, 32'h0000_000A);
    apb(1'b0, `PPDS_OFF_EVT_DATA, 0);
    check("evt data", rd, 32'h0000_044C);
    repeat (5 * CYC) @(posedge pclk);
    i_ppds_meas_src.drive(16'h044C, 1'b0);
    wait_bit(2, 1'b1, t0);
    repeat (20 * CYC) @(posedge pclk);
    i_ppds_meas_src.drive(16'h044C, 1'b1);
    wait_bit(2, 1'b0, t0);
    check("blocked", stage_out.blocked, 1'b1);
    check("no trip", stage_out.trip, 1'b0);
    i_ppds_meas_src.drive(16'h044C, 1'b0);
    wait_bit(2, 1'b1, t0);
    wait_bit(0, 1'b1, t1);
    check("timer fresh", t1, 39 * CYC);
    apb(1'b1, `PPDS_OFF_IRQ_STAT, 32'h0000_0004);
    check("irq clear", irq, 1'b0);
    i_ppds_meas_src.drive(16'h0000, 1'b0);
    wait_bit(3, 1'b0, t0);
    $display("t_block done");
  endtask

  task automatic t_inverse();
    int hi, lo;
    apb(1'b1, `PPDS_OFF_FIXDLY, 0);
    apb(1'b1, `PPDS_OFF_KMUL, 32'h0000_0001);
    apb(1'b1, `PPDS_OFF_CONST_A, 32'h0000_1F40);
    apb(1'b1, `PPDS_OFF_DEN_LAST, 32'h0000_0FA0);
    apb(1'b1, `PPDS_OFF_CTRL, 32'h0000_0001);
    meas(16'h1770, hi);
    meas(16'h04B0, lo);
    check("ratio", hi < lo, 1'b1);
    check("fast curve", hi, CYC);
    check("slow curve", lo, 7 * CYC);
    apb(1'b1, `PPDS_OFF_CTRL, 32'h0000_0003);
    meas(16'h1770, t1);
    check("ieee tail", t1 > hi, 1'b1);
    check("ieee time", t1, 3 * CYC);
    apb(1'b1, `PPDS_OFF_CTRL, 32'h0000_0001);
    apb(1'b1, `PPDS_OFF_FIXDLY, 32'h0000_0002);
    meas(16'h1770, t1);
    check("floor", t1 > hi, 1'b1);
    check("floor time", t1, 9 * CYC);
    $display("t_inverse done");
  endtask

  task automatic t_under();
    apb(1'b1, `PPDS_OFF_FIXDLY, 0);
    apb(1'b1, `PPDS_OFF_CTRL, 32'h0000_0004);
    wait_bit(2, 1'b1, t0);
    check("under trip", stage_out.trip, 1'b1);
    i_ppds_meas_src.drive(16'h0320, 1'b1);
    wait_bit(1, 1'b1, t0);
    check("under evt", evt_valid, 1'b1);
    check("under fault", evt.fault, 2'h3);
    i_ppds_meas_src.drive(16'h03F2, 1'b0);
    wait_bit(2, 1'b1, t0);
    repeat (3 * CYC) @(posedge pclk);
    #1;
    check("under hold", stage_out.picked, 1'b1);
    i_ppds_meas_src.drive(16'h0410, 1'b0);
    wait_bit(3, 1'b0, t1);
    check("under release", t1 <= CYC, 1'b1);
    $display("t_under done");
  endtask

  initial begin
    #200000;
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fixed();
    t_block();
    t_inverse();
    t_under();
    wrap_up();
  end
endmodule
`default_nettype wire
